/* File: src/mismatch_pkg.sv */
// constants for the dual sensor discrepancy check
package mismatch_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned TICK_MS       = 1;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int unsigned WINDOW_MAX_S  = 60;
	localparam int unsigned WINDOW_MAX_MS = WINDOW_MAX_S * MS_PER_S;
	localparam int unsigned WINDOW_W      = 17;
	localparam int unsigned TICK_W        = 16;
	localparam int unsigned SVC_FAULT     = 0;
	localparam int unsigned SVC_LAST_A    = 1;
	localparam int unsigned SVC_LAST_B    = 2;
	localparam int unsigned SVC_CLR_STUCK = 5;
	localparam int unsigned SVC_PENDING   = 6;
	localparam int unsigned SVC_AGREED    = 7;
	localparam logic [7:0]  SVC_RESET     = 8'h00;
	localparam logic        MANUAL_RESET  = 1'b1;
endpackage

/* File: src/dual_sensor_discrepancy_check.sv */
// dual sensor one-out-of-two evaluation with discrepancy supervision
`timescale 1ns/1ps
`default_nettype none
module dual_sensor_discrepancy_check #(
	parameter int unsigned TICK_CYCLES = mismatch_pkg::TICK_CYCLES
) (
	input  wire logic                                clk_sys_i,
	input  wire logic                                reset_i,
	input  wire logic                                sensor_a_in_i,
	input  wire logic                                sensor_b_in_i,
	input  wire logic [mismatch_pkg::WINDOW_W-1:0]   mismatch_window_i,
	input  wire logic                                window_negative_i,
	input  wire logic                                manual_clear_required_i,
	input  wire logic                                clear_request_i,
	output logic                                     agreed_o,
	output logic                                     clear_pending_o,
	output logic                                     mismatch_fault_o,
	output logic [7:0]                               service_info_byte_o
);
	import mismatch_pkg::*;

	// three-stage synchronisers; stage 0 feeds only stage 1
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] sync_c;
	logic [2:0] next_sync_a;
	logic [2:0] next_sync_b;
	logic [2:0] next_sync_c;
	logic       in_a;
	logic       in_b;
	logic       in_c;
	logic       next_in_a;
	logic       next_in_b;
	logic       next_in_c;

	always_comb begin
		next_sync_a = {sync_a[1:0], sensor_a_in_i};
		next_sync_b = {sync_b[1:0], sensor_b_in_i};
		next_sync_c = {sync_c[1:0], clear_request_i};
		next_in_a   = (sync_a[1] == sync_a[2]) ? sync_a[2] : in_a;
		next_in_b   = (sync_b[1] == sync_b[2]) ? sync_b[2] : in_b;
		next_in_c   = (sync_c[1] == sync_c[2]) ? sync_c[2] : in_c;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
			sync_c <= 3'h0;
			in_a   <= 1'b0;
			in_b   <= 1'b0;
			in_c   <= 1'b0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			sync_c <= next_sync_c;
			in_a   <= next_in_a;
			in_b   <= next_in_b;
			in_c   <= next_in_c;
		end
	end

	// millisecond time base: exact at 40 MHz, so error is one tick at most
	logic [TICK_W-1:0]   tick_cnt;
	logic [TICK_W-1:0]   next_tick_cnt;
	logic                tick;
	logic [WINDOW_W-1:0] elapsed;
	logic [WINDOW_W-1:0] next_elapsed;
	logic                prev_a;
	logic                prev_b;
	logic                prev_c;
	logic                fault;
	logic                next_fault;
	logic                pending;
	logic                next_pending;
	logic [7:0]          svc;
	logic [7:0]          next_svc;
	logic                mismatch;
	logic                bad_window;
	logic                expired;
	logic                clear_edge;
	logic                clear_ok;

	assign tick       = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
	assign mismatch   = in_a ^ in_b;
	assign bad_window = window_negative_i
		|| (mismatch_window_i > WINDOW_W'(WINDOW_MAX_MS));
	// zero window expires on the first cycle of a mismatch
	assign expired    = mismatch && (elapsed >= mismatch_window_i);
	assign clear_edge = in_c && !prev_c;
	// manual clear waits for agreement and a fresh edge
	assign clear_ok   = fault && !mismatch && !bad_window
		&& (manual_clear_required_i ? clear_edge : 1'b1);

	always_comb begin
		next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
		next_elapsed  = elapsed;
		if (!mismatch)
			next_elapsed = '0;
		else if (tick && !expired)
			next_elapsed = elapsed + WINDOW_W'(1);
		next_fault = fault;
		if (bad_window || expired)
			next_fault = 1'b1;
		else if (clear_ok)
			next_fault = 1'b0;
		next_pending = manual_clear_required_i && fault && !mismatch
			&& !bad_window && !clear_ok;
		next_svc = svc;
		if (clear_ok)
			next_svc = SVC_RESET;
		// record only on a change: a steady mismatch would wipe the cause
		if (mismatch && !fault && (in_a != prev_a || in_b != prev_b)) begin
			next_svc[SVC_LAST_A] = (in_a != prev_a);
			next_svc[SVC_LAST_B] = (in_b != prev_b);
		end
		// no fault and inputs agree: no cause left to report
		if (!fault && !mismatch) begin
			next_svc[SVC_LAST_A] = 1'b0;
			next_svc[SVC_LAST_B] = 1'b0;
		end
		if (next_fault && manual_clear_required_i && in_c && prev_c)
			next_svc[SVC_CLR_STUCK] = 1'b1;
		next_svc[SVC_FAULT]   = next_fault;
		next_svc[SVC_PENDING] = next_pending;
		next_svc[SVC_AGREED]  = in_a && in_b && !next_fault;
		next_svc[4:3]         = 2'h0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			tick_cnt <= '0;
			elapsed  <= '0;
			prev_a   <= 1'b0;
			prev_b   <= 1'b0;
			prev_c   <= MANUAL_RESET;
			fault    <= 1'b0;
			pending  <= 1'b0;
			svc      <= SVC_RESET;
		end else begin
			tick_cnt <= next_tick_cnt;
			elapsed  <= next_elapsed;
			prev_a   <= in_a;
			prev_b   <= in_b;
			prev_c   <= in_c;
			fault    <= next_fault;
			pending  <= next_pending;
			svc      <= next_svc;
		end
	end

	// agreed output is the registered copy of service bit 7
	assign agreed_o            = svc[SVC_AGREED];
	assign mismatch_fault_o    = fault;
	assign clear_pending_o     = pending;
	assign service_info_byte_o = svc;

	chk_agreed_needs_both: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) agreed_o |-> $past(in_a && in_b))
		else $error("agreed high without both inputs");
	chk_low_forces_off: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) !(in_a && in_b) |=> !agreed_o)
		else $error("agreed high with an input low");
	chk_window_fault: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) expired |=> fault)
		else $error("fault not latched at expiry");
	chk_no_early_fault: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) !fault && !bad_window && !expired |=> !fault)
		else $error("fault without expiry");
	chk_auto_clear: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && !manual_clear_required_i && !mismatch
		&& !bad_window |=> !fault)
		else $error("auto clear missing");
	chk_manual_hold: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && manual_clear_required_i && !clear_edge
		|=> fault)
		else $error("fault cleared without edge");
	chk_pending_rise: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && manual_clear_required_i && !mismatch
		&& !bad_window && !clear_edge |=> pending)
		else $error("clear pending not raised");
	chk_pending_drop: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) mismatch |=> !pending)
		else $error("pending held during mismatch");
	chk_bad_window: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) bad_window |=> fault && !agreed_o)
		else $error("bad window not faulted");
	chk_svc_fault: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) service_info_byte_o[SVC_FAULT] == fault)
		else $error("service bit 0 differs from fault");
	chk_svc_zero: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) service_info_byte_o[4:3] == 2'h0)
		else $error("reserved service bits set");
	chk_pending_clear: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) clear_ok |=> !pending)
		else $error("clear pending held after clear");
	chk_agreed_rise: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) in_a && in_b && !fault && !bad_window
		|=> agreed_o)
		else $error("agreed not raised with both inputs");
	chk_stuck_flag: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && manual_clear_required_i && in_c
		&& prev_c |=> service_info_byte_o[SVC_CLR_STUCK])
		else $error("stuck clear not flagged");
	chk_cause_held: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && !clear_ok
		|=> $stable(service_info_byte_o[SVC_LAST_B:SVC_LAST_A]))
		else $error("fault cause bits changed before clear");
	chk_cause_a: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) mismatch && !fault && (in_a != prev_a)
		&& (in_b == prev_b) |=> service_info_byte_o[SVC_LAST_A]
		&& !service_info_byte_o[SVC_LAST_B])
		else $error("cause bits miss a change on sensor a");
	chk_tick_range: assert property (@(posedge clk_sys_i)
		disable iff (reset_i) tick_cnt <= TICK_W'(TICK_CYCLES - 1))
		else $error("time base counter out of range");
	cov_fault: cover property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(fault));
	cov_auto_clear: cover property (@(posedge clk_sys_i)
		disable iff (reset_i) fault && !manual_clear_required_i ##1 !fault);
	cov_manual_clear: cover property (@(posedge clk_sys_i)
		disable iff (reset_i) pending ##1 !fault);
	cov_stuck: cover property (@(posedge clk_sys_i) disable iff (reset_i)
		svc[SVC_CLR_STUCK]);
	cov_agreed: cover property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(agreed_o));
endmodule
`default_nettype wire

/* File: sim/sensor_button_model.sv */
// model of the two safety sensors and the clear button
`timescale 1ns/1ps
`default_nettype none
module sensor_button_model (
	input  wire logic clk_i,
	input  wire logic want_a_i,
	input  wire logic want_b_i,
	input  wire logic want_clr_i,
	output var  logic sensor_a_o,
	output var  logic sensor_b_o,
	output var  logic clear_o
);
	// both sensors rest at their safe state 0
	initial begin
		sensor_a_o = 1'b0;
		sensor_b_o = 1'b0;
		clear_o    = 1'b0;
	end
	// levels move just after the edge; the operator makes the clear edge
	always @(posedge clk_i) begin
		sensor_a_o <= #1 want_a_i;
		sensor_b_o <= #1 want_b_i;
		clear_o    <= #1 want_clr_i;
	end
endmodule
`default_nettype wire

/* File: sim/dual_sensor_discrepancy_check_tb.sv */
// self-checking bench for the dual sensor discrepancy check
`timescale 1ns/1ps
`default_nettype none
module dual_sensor_discrepancy_check_tb;
	import mismatch_pkg::*;
	// a short tick keeps windows to a few dozen cycles
	localparam int unsigned TICKS = 4;
	logic                clk_sys = 1'b0;
	logic                reset = 1'b1;
	logic                want_a = 1'b0, want_b = 1'b0, want_clr = 1'b0;
	logic                man = 1'b1, neg = 1'b0;
	logic [WINDOW_W-1:0] win = 17'h00014;
	logic                pin_a, pin_b, pin_clr, agreed, pending, fault;
	logic [7:0]          svc;
	logic                sa, sb;
	int                  fail_count = 0, check_count = 0;

	always #12.5 clk_sys = ~clk_sys;

	sensor_button_model partner (.clk_i(clk_sys), .want_a_i(want_a),
		.want_b_i(want_b), .want_clr_i(want_clr), .sensor_a_o(pin_a),
		.sensor_b_o(pin_b), .clear_o(pin_clr));

	dual_sensor_discrepancy_check #(.TICK_CYCLES(TICKS)) dut (
		.clk_sys_i(clk_sys), .reset_i(reset), .sensor_a_in_i(pin_a),
		.sensor_b_in_i(pin_b), .mismatch_window_i(win),
		.window_negative_i(neg), .manual_clear_required_i(man),
		.clear_request_i(pin_clr), .agreed_o(agreed),
		.clear_pending_o(pending), .mismatch_fault_o(fault),
		.service_info_byte_o(svc));

	function automatic logic [2:0] outs(input logic a, b, flt, pnd);
		return {a & b & ~flt, pnd, flt};
	endfunction

	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic drive(input logic a, b, c, input int n);
		want_a = a;
		want_b = b;
		want_clr = c;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk_sys);
		fail_count++;
		finish_test;
	end

	initial begin
		void'($urandom(79692));
		repeat (12) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		@(posedge clk_sys);
		#1;
		check({agreed, pending, fault, svc}, 11'h000);
		drive(1, 1, 0, 10);
		check({agreed, pending, fault}, outs(1, 1, 0, 0));
		check(svc, 8'h80);
		// short random mismatches stay inside the 80 cycle window
		for (int i = 0; i < 20; i++) begin
			sa = $urandom_range(0, 1);
			sb = $urandom_range(0, 1);
			drive(sa, sb, 0, $urandom_range(6, 30));
			check({agreed, pending, fault}, outs(sa, sb, 0, 0));
			drive(1, 1, 0, 8);
		end
		win = 17'h00003;
		drive(0, 0, 0, 10);
		drive(1, 0, 0, 8);
		check({agreed, pending, fault}, 3'h0);
		drive(1, 0, 0, 32);
		check({agreed, pending, fault}, outs(1, 0, 1, 0));
		check(svc, 8'h03);
		drive(1, 1, 0, 10);
		check({agreed, pending, fault}, outs(1, 1, 1, 1));
		check(svc, 8'h43);
		drive(1, 0, 0, 8);
		check({agreed, pending, fault}, outs(1, 0, 1, 0));
		drive(1, 1, 0, 10);
		drive(1, 1, 1, 10);
		check({agreed, pending, fault}, outs(1, 1, 0, 0));
		check(svc, 8'h80);
		// clear still held high: no edge for this fault
		drive(0, 0, 1, 10);
		drive(0, 1, 1, 40);
		check(svc, 8'h25);
		drive(1, 1, 0, 10);
		check({agreed, pending, fault}, outs(1, 1, 1, 1));
		drive(1, 1, 1, 10);
		check({agreed, pending, fault}, outs(1, 1, 0, 0));
		// automatic clearing, restart assumed blocked elsewhere
		man = 1'b0;
		drive(0, 1, 0, 40);
		check({agreed, pending, fault}, outs(0, 1, 1, 0));
		drive(1, 1, 0, 10);
		check({agreed, pending, fault}, outs(1, 1, 0, 0));
		for (int k = 0; k < 3; k++) begin
			win = (k == 0) ? 17'h0EA61 : 17'h0EA60;
			neg = (k == 1);
			drive(1, 1, 0, 10);
			check({agreed, fault, svc[0]}, (k == 2) ? 3'h4 : 3'h3);
		end
		finish_test;
	end
endmodule
`default_nettype wire
